// ===== verilog/dsp_port.sv
// serial datagram port: forty-bit mode-3 slave with one-deep read pipeline
`timescale 1ns/1ps
module dsp_port
(
  // system clock, reset and freeze
  input  wire logic                               clk_sys,
  input  wire logic                               reset,
  input  wire logic                               clk_en,
  // serial link pins
  input  wire logic                               sck,
  input  wire logic                               sdi,
  input  wire logic                               chip_select_low,
  output logic                                    sdo,
  output logic                                    sdo_oe_n,
  // access port towards the driver register set
  output logic                                    reg_wr,
  output logic                                    reg_rd,
  output logic      [dsp_pkg::ADDR_BITS-1:0]      reg_addr,
  output logic      [dsp_pkg::DATA_BITS-1:0]      reg_wdata,
  input  wire logic [dsp_pkg::DATA_BITS-1:0]      reg_rdata,
  // live status flags from the driver core
  input  wire logic [dsp_pkg::STATUS_BITS-1:0]    status_in
);

  // ------------------------------------------------------------
  // pin conditioning
  // ------------------------------------------------------------
  logic [dsp_pkg::PIN_COUNT-1:0] pin_clean;
  logic [dsp_pkg::PIN_COUNT-1:0] pin_prev_reg;

  dsp_sync u_sync
  (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .clk_en    (clk_en),
    .pin_in    ({chip_select_low, sdi, sck}),
    .pin_clean (pin_clean)
  );

  // edge decode on the cleaned levels; each serial clock phase must last two clk_sys cycles, so at most a quarter of clk_sys
  wire sck_rise = pin_clean[dsp_pkg::PIN_SCK] & ~pin_prev_reg[dsp_pkg::PIN_SCK];
  wire sck_fall = ~pin_clean[dsp_pkg::PIN_SCK] & pin_prev_reg[dsp_pkg::PIN_SCK];
  wire cs_fall  = ~pin_clean[dsp_pkg::PIN_CS] & pin_prev_reg[dsp_pkg::PIN_CS];
  wire cs_rise  = pin_clean[dsp_pkg::PIN_CS] & ~pin_prev_reg[dsp_pkg::PIN_CS];
  wire selected = ~pin_clean[dsp_pkg::PIN_CS];
  wire bit_in   = pin_clean[dsp_pkg::PIN_SDI];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [dsp_pkg::DATAGRAM_BITS-1:0] shift_reg;
  logic [dsp_pkg::DATAGRAM_BITS-1:0] shift_next;
  logic [dsp_pkg::CNT_BITS-1:0]      count_reg;
  logic [dsp_pkg::CNT_BITS-1:0]      count_next;
  logic [dsp_pkg::DATA_BITS-1:0]     resp_data_reg;
  logic [dsp_pkg::DATA_BITS-1:0]     resp_data_next;
  logic [dsp_pkg::STATUS_BITS-1:0]   status_reg;
  logic                              rd_pend_reg;
  logic                              sdo_reg;
  logic                              sdo_next;
  logic                              oe_n_reg;
  dsp_pkg::dsp_req_t                 req_reg;
  dsp_pkg::dsp_req_t                 req_next;

  // ------------------------------------------------------------
  // datagram decode
  // ------------------------------------------------------------
  dsp_pkg::dsp_cmd_t  cmd;
  dsp_pkg::dsp_resp_t resp;

  // the last forty bits before select rises form the command
  assign cmd  = dsp_pkg::dsp_cmd_t'(shift_reg);
  // answer is status byte ahead of the 32-bit data word
  assign resp = '{status: status_reg, data: resp_data_reg};

  // a frame with fewer than forty clocks is dropped as incomplete
  wire frame_ok  = (count_reg == dsp_pkg::FULL_COUNT);
  wire do_access = cs_rise & frame_ok;
  wire is_write  = cmd.write_not_read_flag;

  // ------------------------------------------------------------
  // shift path: one register serves both directions, so surplus bits
  // come back out forty clocks later without extra storage
  // ------------------------------------------------------------
  assign shift_next = cs_fall ? dsp_pkg::DATAGRAM_BITS'(resp)
                    : (selected & sck_rise) ? {shift_reg[dsp_pkg::DATAGRAM_BITS-2:0], bit_in}
                    : shift_reg;
  assign count_next = cs_fall ? '0
                    : (selected & sck_rise & ~frame_ok) ? count_reg + 6'h01
                    : count_reg;

  // output bit changes only after a falling clock, first bit at select
  assign sdo_next = cs_fall ? resp.status[dsp_pkg::STATUS_BITS-1]
                  : (selected & sck_fall) ? shift_reg[dsp_pkg::DATAGRAM_BITS-1]
                  : sdo_reg;

  // ------------------------------------------------------------
  // access request towards the register set
  // ------------------------------------------------------------
  // reads never raise the write strobe; their data field is ignored
  assign req_next = '{wr:    do_access & is_write,
                      rd:    do_access & ~is_write,
                      addr:  do_access ? cmd.addr : req_reg.addr,
                      wdata: (do_access & is_write) ? cmd.data : req_reg.wdata};

  // write echoes its data; a read takes the register value a cycle later
  assign resp_data_next = (do_access & is_write) ? cmd.data
                        : rd_pend_reg ? reg_rdata
                        : resp_data_reg;

  // link-side registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_prev_reg <= dsp_pkg::PIN_IDLE;
      shift_reg    <= '0;
      count_reg    <= '0;
      sdo_reg      <= 1'b0;
      oe_n_reg     <= 1'b1;
    end
    else if (clk_en)
    begin
      pin_prev_reg <= pin_clean;
      shift_reg    <= shift_next;
      count_reg    <= count_next;
      sdo_reg      <= sdo_next;
      oe_n_reg     <= ~selected;
    end
  end

  // access-side registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      req_reg       <= '{wr: 1'b0, rd: 1'b0, addr: '0, wdata: dsp_pkg::DATA_RST};
      rd_pend_reg   <= 1'b0;
      resp_data_reg <= dsp_pkg::DATA_RST;
      status_reg    <= dsp_pkg::STAT_RST;
    end
    else if (clk_en)
    begin
      req_reg       <= req_next;
      rd_pend_reg   <= req_next.rd;
      resp_data_reg <= resp_data_next;
      // fresh status captured at the close of each access
      if (cs_rise)
        status_reg <= status_in;
    end
  end

  // outputs straight from flops
  assign sdo       = sdo_reg;
  assign sdo_oe_n  = oe_n_reg;
  assign reg_wr    = req_reg.wr;
  assign reg_rd    = req_reg.rd;
  assign reg_addr  = req_reg.addr;
  assign reg_wdata = req_reg.wdata;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_full_write;
    clk_en && do_access && is_write;
  endsequence

  sequence s_full_read;
    clk_en && do_access && !is_write;
  endsequence

  property p_write_strobe;
    @(posedge clk_sys) disable iff (reset)
    s_full_write |=> reg_wr && !reg_rd && reg_wdata == $past(cmd.data);
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("write not issued");

  property p_write_addr;
    @(posedge clk_sys) disable iff (reset)
    clk_en && do_access |=> reg_addr == $past(shift_reg[dsp_pkg::ADDR_MSB:dsp_pkg::ADDR_LSB]);
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("address field wrong");

  property p_read_no_write;
    @(posedge clk_sys) disable iff (reset)
    s_full_read |=> reg_rd && !reg_wr && $stable(reg_wdata);
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("read disturbed reg");

  property p_short_frame;
    @(posedge clk_sys) disable iff (reset)
    clk_en && cs_rise && count_reg < dsp_pkg::FULL_COUNT |=> !reg_wr && !reg_rd;
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("short frame acted on");

  property p_echo;
    @(posedge clk_sys) disable iff (reset)
    reg_wr |-> resp_data_reg == reg_wdata;
  endproperty
  a_echo: assert property (p_echo) else $error("write data not echoed");

  property p_read_return;
    @(posedge clk_sys) disable iff (reset)
    reg_rd && clk_en |=> resp_data_reg == $past(reg_rdata);
  endproperty
  a_read_return: assert property (p_read_return) else $error("read data lost");

  property p_status_lead;
    @(posedge clk_sys) disable iff (reset)
    clk_en && cs_fall |=> shift_reg[dsp_pkg::STATUS_MSB:dsp_pkg::STATUS_LSB] == status_reg
                          && sdo == status_reg[dsp_pkg::STATUS_BITS-1];
  endproperty
  a_status_lead: assert property (p_status_lead) else $error("status byte missing");

  property p_status_latch;
    @(posedge clk_sys) disable iff (reset)
    clk_en && cs_rise |=> status_reg == $past(status_in);
  endproperty
  a_status_latch: assert property (p_status_latch) else $error("status not latched");

  property p_drive_fall;
    @(posedge clk_sys) disable iff (reset)
    clk_en && selected && sck_fall |=> sdo == $past(shift_reg[dsp_pkg::DATAGRAM_BITS-1]);
  endproperty
  a_drive_fall: assert property (p_drive_fall) else $error("sdo not updated");

  property p_hold_rise;
    @(posedge clk_sys) disable iff (reset)
    clk_en && selected && sck_rise |=> $stable(sdo);
  endproperty
  a_hold_rise: assert property (p_hold_rise) else $error("sdo moved on rise");

endmodule

// ===== shared/dsp_pkg.sv
// shared constants and carrier types for the driver serial datagram port
package dsp_pkg;

  // ------------------------------------------------------------
  // datagram geometry
  // ------------------------------------------------------------
  localparam int DATAGRAM_BITS = 40;
  localparam int DATA_BITS     = 32;
  localparam int ADDR_BITS     = 7;
  localparam int STATUS_BITS   = 8;
  localparam int CNT_BITS      = 6;
  localparam logic [CNT_BITS-1:0] FULL_COUNT = 6'h28;  // forty serial clocks

  // field positions inside a datagram
  localparam int FLAG_POS   = 39;
  localparam int ADDR_MSB   = 38;
  localparam int ADDR_LSB   = 32;
  localparam int STATUS_MSB = 39;
  localparam int STATUS_LSB = 32;

  // ------------------------------------------------------------
  // pin conditioning and reset values
  // ------------------------------------------------------------
  localparam int SYNC_STAGES = 3;
  localparam int PIN_COUNT   = 3;
  localparam int PIN_SCK     = 0;
  localparam int PIN_SDI     = 1;
  localparam int PIN_CS      = 2;
  localparam logic [PIN_COUNT-1:0] PIN_IDLE  = 3'h5;   // clock high, data low, deselected
  localparam logic [DATA_BITS-1:0] DATA_RST  = 32'h00000000;
  localparam logic [STATUS_BITS-1:0] STAT_RST = 8'h00;

  // incoming command as it sits in the shift register
  typedef struct packed {
    logic                 write_not_read_flag;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } dsp_cmd_t;

  // outgoing answer loaded at the start of a frame
  typedef struct packed {
    logic [STATUS_BITS-1:0] status;
    logic [DATA_BITS-1:0]   data;
  } dsp_resp_t;

  // register-side access request
  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] wdata;
  } dsp_req_t;

endpackage

// ===== verilog/dsp_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dsp_sync
(
  // clock and control
  input  wire logic                              clk_sys,
  input  wire logic                              reset,
  input  wire logic                              clk_en,
  // pins in, clean levels out
  input  wire logic [dsp_pkg::PIN_COUNT-1:0]     pin_in,
  output logic      [dsp_pkg::PIN_COUNT-1:0]     pin_clean
);

  genvar g;
  generate
    for (g = 0; g < dsp_pkg::PIN_COUNT; g++)
    begin : g_pin
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic clean_reg;
      // first stage is read only by the second; the filter waits on stages two and three
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          s1_reg    <= dsp_pkg::PIN_IDLE[g];
          s2_reg    <= dsp_pkg::PIN_IDLE[g];
          s3_reg    <= dsp_pkg::PIN_IDLE[g];
          clean_reg <= dsp_pkg::PIN_IDLE[g];
        end
        else if (clk_en)
        begin
          s1_reg <= pin_in[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
            clean_reg <= s3_reg;
        end
      end
      assign pin_clean[g] = clean_reg;
    end
  endgenerate

endmodule

// ===== verif/dsp_master_model.sv
// serial link master model driving mode-3 frames of nb bits
`timescale 1ns/1ps
module dsp_master_model
(
  // system clock, only used to pace the link
  input  wire logic clk_sys,
  // link pins
  output logic      sck,
  output logic      sdi,
  output logic      chip_select_low,
  input  wire logic sdo
);
  // ------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------
  initial
  begin
    sck = 1'b1;
    sdi = 1'b0;
    chip_select_low = 1'b1;
  end

  // ------------------------------------------------------------
  // one frame of nb bits; half is each clock phase in clk_sys cycles
  // ------------------------------------------------------------
  // sdo is read just before each fall, since the port answers a few cycles late
  task automatic frame(input logic [47:0] tx, input int nb, input int half,
                       output logic [47:0] rx);
    rx = '0;
    @(posedge clk_sys);
    chip_select_low <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (int i = nb - 1; i >= 0; i--)
    begin
      sck <= 1'b0;
      sdi <= tx[i];
      repeat (half) @(posedge clk_sys);
      sck <= 1'b1;
      repeat (half) @(posedge clk_sys);
      // end of the high phase: the bit driven after this clock's fall has settled
      rx = {rx[46:0], sdo};
    end
    chip_select_low <= 1'b1;
    sdi <= ~sdi;  // released line shows no stale bit
  endtask
endmodule

// ===== verif/dsp_port_test.sv
// self-checking bench for the serial datagram port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module dsp_port_test;
  logic                               clk_sys, reset, clk_en, sck, sdi, chip_select_low;
  logic                               sdo, sdo_oe_n, reg_wr, reg_rd;
  logic [dsp_pkg::ADDR_BITS-1:0]      reg_addr;
  logic [dsp_pkg::DATA_BITS-1:0]      reg_wdata, reg_rdata, prev_val;
  logic [dsp_pkg::STATUS_BITS-1:0]    status_in, st_prev;
  logic [dsp_pkg::DATA_BITS-1:0]      regs [128];
  logic [dsp_pkg::DATA_BITS-1:0]      ref_mem [128];
  int                                 err_total, checks_done, acc_cnt;
  // a released output shows the inverse of its last bit, so stale data cannot pass
  wire logic                          sdo_line = sdo_oe_n ? ~sdo : sdo;

  dsp_port dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .sck(sck), .sdi(sdi),
    .chip_select_low(chip_select_low), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .status_in(status_in));
  dsp_master_model m (.clk_sys(clk_sys), .sck(sck), .sdi(sdi),
    .chip_select_low(chip_select_low), .sdo(sdo_line));

  // ------------------------------------------------------------
  // clock, watchdog and register set behind the port
  // ------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // a hung frame must still reach the verdict
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    close_out();
  end

  // the port takes read data in the cycle of its read strobe, so the model answers at once
  always_comb reg_rdata = regs[reg_addr];

  // writes land on the edge that samples the write strobe
  always @(posedge clk_sys)
  begin
    if (reg_wr === 1'b1)
      regs[reg_addr] <= reg_wdata;
    if (reg_wr === 1'b1 || reg_rd === 1'b1)
      acc_cnt <= acc_cnt + 1;
  end

  // ------------------------------------------------------------
  // verdict
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // one frame with expectations from the reference copy
  // ------------------------------------------------------------
  task automatic xfer(input logic [47:0] tx, input int nb);
    logic [47:0]       rx;
    logic [39:0]       resp;
    dsp_pkg::dsp_cmd_t cmd;
    int                acc0;
    cmd = tx[39:0];
    acc0 = acc_cnt;
    status_in <= 8'($urandom);
    // four clk_sys cycles per phase gives the 200 ns link period
    m.frame(tx, nb, 4, rx);
    repeat (12) @(posedge clk_sys);
    `CHK("sdo_oe_n", 1'b1, sdo_oe_n)
    `CHK("accesses", (nb >= 40) ? 1 : 0, acc_cnt - acc0)
    if (nb >= 40)
    begin
      resp = 40'(rx >> (nb - 40));
      `CHK("status", st_prev, resp[39:32])
      `CHK("data", prev_val, resp[31:0])
      if (nb > 40)
        `CHK("excess", tx[47:40], rx[7:0])
      if (cmd.write_not_read_flag)
      begin
        ref_mem[cmd.addr] = cmd.data;
        prev_val = cmd.data;
      end
      else
        prev_val = ref_mem[cmd.addr];
    end
    st_prev = status_in;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hF08A4625));
    reset = 1'b1;
    clk_en = 1'b1;
    status_in = 8'h00;
    acc_cnt = 0;
    st_prev = dsp_pkg::STAT_RST;
    prev_val = dsp_pkg::DATA_RST;
    for (int i = 0; i < 128; i++)
    begin
      regs[i] = $urandom;
      ref_mem[i] = regs[i];
    end
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    // pipelined reads, lowest and highest address
    xfer(48'h0012_0000_0000, 40);
    xfer(48'h0000_0000_0000, 40);
    xfer(48'h007F_0000_0000, 40);
    // write, write again, then dummy-data read must not disturb it
    xfer(48'h0090_0001_1F10, 40);
    xfer(48'h0090_0002_1807, 40);
    xfer(48'h0010_FFFF_FFFF, 40);
    xfer(48'h0010_0000_0000, 40);
    // freeze between frames: the pending read result must survive it
    clk_en <= 1'b0;
    repeat (6) @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    // short frame is ignored, the pipeline keeps its value
    xfer(48'h0000_000F_0F0F, 20);
    xfer(48'h00FF_8000_0001, 40);
    // eight extra clocks: the last forty bits count
    xfer(48'hA585_1234_5678, 48);
    xfer(48'h0005_0000_0000, 40);
    // random mix of reads and writes
    for (int k = 0; k < 24; k++)
      xfer({8'h00, 1'($urandom), 7'($urandom), 32'($urandom)}, 40);
    xfer(48'h0000_0000_0000, 40);
    close_out();
  end
endmodule
